// *** design/hapd_map.vh ***
// Purpose: constants for the host aperture decoder
// Assumes: included by bare name; definitions only
// Notes: software port offsets are byte addresses
`ifndef HAPD_MAP_VH
`define HAPD_MAP_VH
// software port offsets
`define HAPD_SW_CTRL 8'h00
`define HAPD_SW_REG0_BASE 8'h04
`define HAPD_SW_REG1_BASE 8'h08
`define HAPD_SW_LIN0_BASE 8'h0c
`define HAPD_SW_LIN1_BASE 8'h10
`define HAPD_SW_FB_SIZE 8'h14
`define HAPD_SW_AGP_OFF 8'h18
`define HAPD_SW_AGP_CODE 8'h1c
`define HAPD_SW_IO_BASE 8'h20
`define HAPD_SW_STATUS 8'h24
// control field positions
`define HAPD_CTRL_VGA_EN 0
`define HAPD_CTRL_SEL_LO 1
`define HAPD_CTRL_SEL_HI 2
`define HAPD_CTRL_BE0 3
`define HAPD_CTRL_BE1 4
`define HAPD_CTRL_AGP 5
// reset values
`define HAPD_RST_CTRL 6'h00
`define HAPD_RST_FB_SIZE 26'h2000000
// register offsets seen through the apertures
`define HAPD_OFF_INDEX 14'h0000
`define HAPD_OFF_DATA 14'h0004
`define HAPD_OFF_PLL_INDEX 14'h0008
`define HAPD_OFF_PLL_DATA 14'h000c
`define HAPD_OFF_LIN0 14'h00f0
`define HAPD_OFF_LIN1 14'h00f4
`define HAPD_OFF_REG1 14'h00f8
`define HAPD_OFF_FBSZ 14'h00fc
`define HAPD_IO_END 14'h0100
`define HAPD_MM_END 14'h0f00
`define HAPD_CFG_END 14'h1000
`define HAPD_CCE_END 14'h1400
`define HAPD_GUI_END 14'h2000
`define HAPD_IDX_REG0 14'h0f18
// memory limits
`define HAPD_FB_MAX 27'h2000000
`define HAPD_AGP_UNIT 27'h0400000
// host spaces
`define HAPD_SP_MEM 2'h0
`define HAPD_SP_IO 2'h1
`define HAPD_SP_CFG 2'h2
// target groups
`define HAPD_G_NONE 4'h0
`define HAPD_G_NGIO 4'h1
`define HAPD_G_NGMM 4'h2
`define HAPD_G_CFGM 4'h3
`define HAPD_G_CCE 4'h4
`define HAPD_G_GUI 4'h5
`define HAPD_G_POS 4'h6
`define HAPD_G_VGAIO 4'h7
`define HAPD_G_VGAMEM 4'h8
`define HAPD_G_FB 4'h9
`define HAPD_G_AGP 4'ha
`define HAPD_G_PLL 4'hb
// refusal causes
`define HAPD_C_OK 3'h0
`define HAPD_C_UNCLAIMED 3'h1
`define HAPD_C_WIDTH 3'h2
`define HAPD_C_RO 3'h3
`define HAPD_C_BUSY 3'h4
`endif

// *** design/hapd_top.v ***
// Purpose: host cycle decode onto register groups and apertures
// Assumes: host strobes synchronous to mclk, byte enables in one dword
// Notes: forwarded reads return data outside this block
`timescale 1ns/1ps
`include "hapd_map.vh"
module hapd_top (
    input wire mclk,
    input wire nrst,
    input wire clk_en,
    input wire hst_req,
    input wire [1:0] hst_space,
    input wire hst_wr,
    input wire [31:0] hst_addr,
    input wire [3:0] hst_be,
    input wire [31:0] hst_wdata,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg tgt_valid,
    output reg [3:0] tgt_group,
    output reg [25:0] tgt_addr,
    output reg [3:0] tgt_be,
    output reg tgt_wr,
    output reg [31:0] tgt_wdata,
    output reg tgt_swap,
    output reg tgt_agp_master,
    output reg hst_rvalid,
    output reg [31:0] hst_rdata,
    output reg hst_refuse,
    output reg hst_busy
);
    localparam ST_IDLE = 1'b0;
    localparam ST_SPLIT = 1'b1;

    // software-owned settings
    reg [5:0] ctrl_ff; // vga enable, window select, endianness, agp
    reg [17:0] reg0_base_ff; // register aperture bases, 16KB aligned, low 8KB decoded
    reg [17:0] reg1_base_ff;
    reg [5:0] lin0_base_ff; // linear window bases, 64MB each
    reg [5:0] lin1_base_ff;
    reg [25:0] fb_size_ff; // installed frame memory in bytes
    reg [25:0] agp_off_ff; // agp image start inside a window
    reg [1:0] agp_code_ff; // agp image size code
    reg [23:0] io_base_ff; // io register space, 256 bytes
    // host-side state
    reg state_ff;
    reg [13:0] index_ff; // host indirect index
    reg [3:0] rem_be_ff; // byte lanes still to issue
    reg [2:0] cause_ff; // last refusal cause
    reg [7:0] refuse_cnt_ff; // refusals seen, saturating

    // byte count and lowest lane of the current request
    wire [2:0] nbytes = {2'b00, hst_be[0]} + {2'b00, hst_be[1]}
        + {2'b00, hst_be[2]} + {2'b00, hst_be[3]};
    wire [3:0] lo_be = hst_be & (~hst_be + 4'h1);
    wire [3:0] rem_lo = rem_be_ff & (~rem_be_ff + 4'h1);
    wire [3:0] rem_rest = rem_be_ff & ~rem_lo;
    wire [26:0] agp_bytes = `HAPD_AGP_UNIT << agp_code_ff;
    wire [26:0] fb_lim = ({1'b0, fb_size_ff} > `HAPD_FB_MAX) ?
        `HAPD_FB_MAX : {1'b0, fb_size_ff};

    // decoder results
    reg [3:0] d_grp;
    reg [25:0] d_off;
    reg [2:0] d_cause;
    reg d_local;
    reg [31:0] d_ldata;
    reg d_split;
    reg d_swap;
    reg d_idx_wr;
    reg [13:0] r_off;
    reg ap_hit;
    reg io_hit;
    reg l0_hit;
    reg l1_hit;
    reg [26:0] l_off;
    reg leg_hit;

    // classify one register offset; io flag limits to low range
    function [3:0] grp_of;
        input [13:0] off;
        input via_io;
        begin
            if (off < `HAPD_IO_END)
                grp_of = via_io ? `HAPD_G_NGIO : `HAPD_G_NGMM;
            else if (via_io)
                grp_of = `HAPD_G_NONE;
            else if (off < `HAPD_MM_END)
                grp_of = `HAPD_G_NGMM;
            else if (off < `HAPD_CFG_END)
                grp_of = `HAPD_G_CFGM;
            else if (off < `HAPD_CCE_END)
                grp_of = `HAPD_G_CCE;
            else if (off < `HAPD_GUI_END)
                grp_of = `HAPD_G_GUI;
            else
                grp_of = `HAPD_G_NONE;
        end
    endfunction

    // address decode of the incoming host cycle
    always @* begin
        d_grp = `HAPD_G_NONE;
        d_off = 26'h0000000;
        d_cause = `HAPD_C_OK;
        d_local = 1'b0;
        d_ldata = 32'h00000000;
        d_split = 1'b0;
        d_swap = 1'b0;
        d_idx_wr = 1'b0;
        r_off = 14'h0000;
        // both register apertures decode alike
        ap_hit = (hst_space == `HAPD_SP_MEM) && !hst_addr[13] &&
            ((hst_addr[31:14] == reg0_base_ff) ||
            (hst_addr[31:14] == reg1_base_ff));
        io_hit = (hst_space == `HAPD_SP_IO) &&
            (hst_addr[31:8] == io_base_ff);
        l0_hit = (hst_space == `HAPD_SP_MEM) &&
            (hst_addr[31:26] == lin0_base_ff);
        l1_hit = (hst_space == `HAPD_SP_MEM) &&
            (hst_addr[31:26] == lin1_base_ff);
        l_off = {1'b0, hst_addr[25:2], 2'b00};
        // legacy memory window, position from the select field
        case (ctrl_ff[`HAPD_CTRL_SEL_HI:`HAPD_CTRL_SEL_LO])
            2'h0: leg_hit = hst_addr[31:17] == 15'h0005;
            2'h1: leg_hit = hst_addr[31:16] == 16'h000a;
            2'h2: leg_hit = hst_addr[31:15] == 17'h00016;
            default: leg_hit = hst_addr[31:15] == 17'h00017;
        endcase
        leg_hit = leg_hit && ctrl_ff[`HAPD_CTRL_VGA_EN] &&
            (hst_space == `HAPD_SP_MEM);
        if (hst_space == `HAPD_SP_CFG) begin
            // setup registers answer config cycles only
            d_grp = `HAPD_G_POS;
            d_off = {18'h00000, hst_addr[7:2], 2'b00};
        end else if (ap_hit || io_hit) begin
            r_off = io_hit ? {6'h00, hst_addr[7:2], 2'b00} :
                {hst_addr[13:2], 2'b00};
            // lanes pick bytes of the dword at r_off
            d_off = {12'h000, r_off};
            d_grp = grp_of(r_off, io_hit);
            if (r_off == `HAPD_OFF_INDEX) begin
                d_local = 1'b1;
                d_idx_wr = hst_wr;
                d_ldata = {18'h00000, index_ff};
            end else if (r_off == `HAPD_OFF_DATA) begin
                if (index_ff == `HAPD_IDX_REG0) begin
                    d_local = 1'b1;
                    d_ldata = {reg0_base_ff, 14'h0000};
                end else begin
                    // indirect target reached by the index
                    d_off = {12'h000, index_ff[13:2], 2'b00};
                    d_grp = grp_of(index_ff, 1'b0);
                end
            end else if (r_off == `HAPD_OFF_PLL_DATA) begin
                d_grp = `HAPD_G_PLL;
                if (nbytes != 3'h1)
                    d_cause = `HAPD_C_WIDTH;
            end else if (r_off == `HAPD_OFF_LIN0) begin
                d_local = 1'b1;
                d_ldata = {lin0_base_ff, 26'h0000000};
            end else if (r_off == `HAPD_OFF_LIN1) begin
                d_local = 1'b1;
                d_ldata = {lin1_base_ff, 26'h0000000};
            end else if (r_off == `HAPD_OFF_REG1) begin
                d_local = 1'b1;
                d_ldata = {reg1_base_ff, 14'h0000};
            end else if (r_off == `HAPD_OFF_FBSZ) begin
                d_local = 1'b1;
                d_ldata = {6'h00, fb_size_ff};
            end
            // local answers other than the index are read-only
            if (d_local && hst_wr && !d_idx_wr)
                d_cause = `HAPD_C_RO;
            if (!d_local && d_grp == `HAPD_G_NONE)
                d_cause = `HAPD_C_UNCLAIMED;
            if (d_grp == `HAPD_G_CFGM && hst_wr)
                d_cause = `HAPD_C_RO;
            if (d_grp == `HAPD_G_GUI && hst_be != 4'hf)
                d_cause = `HAPD_C_WIDTH;
        end else if (hst_space == `HAPD_SP_IO) begin
            // vga ports 3b0-3df, dac included
            if (ctrl_ff[`HAPD_CTRL_VGA_EN] &&
                hst_addr[31:16] == 16'h0000 &&
                hst_addr[15:4] >= 12'h03b &&
                hst_addr[15:4] <= 12'h03d) begin
                d_grp = `HAPD_G_VGAIO;
                d_off = {10'h000, hst_addr[15:2], 2'b00};
                d_split = nbytes > 3'h1;
            end else begin
                d_cause = `HAPD_C_UNCLAIMED;
            end
        end else if (l0_hit || l1_hit) begin
            d_swap = l0_hit ? ctrl_ff[`HAPD_CTRL_BE0] :
                ctrl_ff[`HAPD_CTRL_BE1];
            d_off = l_off[25:0];
            if (l_off < fb_lim) begin
                d_grp = `HAPD_G_FB;
            end else if (ctrl_ff[`HAPD_CTRL_AGP] &&
                l_off >= {1'b0, agp_off_ff} &&
                (l_off - {1'b0, agp_off_ff}) < agp_bytes) begin
                d_grp = `HAPD_G_AGP;
                d_off = l_off[25:0] - agp_off_ff;
            end else begin
                d_cause = `HAPD_C_UNCLAIMED;
            end
        end else if (leg_hit) begin
            d_grp = `HAPD_G_VGAMEM;
            d_off = {6'h00, hst_addr[19:2], 2'b00};
        end else begin
            d_cause = `HAPD_C_UNCLAIMED;
        end
    end

    // host engine: forward, answer locally or split into bytes
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            index_ff <= 14'h0000;
            rem_be_ff <= 4'h0;
            cause_ff <= `HAPD_C_OK;
            refuse_cnt_ff <= 8'h00;
            tgt_valid <= 1'b0;
            tgt_group <= `HAPD_G_NONE;
            tgt_addr <= 26'h0000000;
            tgt_be <= 4'h0;
            tgt_wr <= 1'b0;
            tgt_wdata <= 32'h00000000;
            tgt_swap <= 1'b0;
            tgt_agp_master <= 1'b0;
            hst_rvalid <= 1'b0;
            hst_rdata <= 32'h00000000;
            hst_refuse <= 1'b0;
            hst_busy <= 1'b0;
        end else if (clk_en) begin
            // pulses default low each cycle
            tgt_valid <= 1'b0;
            tgt_agp_master <= 1'b0;
            hst_rvalid <= 1'b0;
            hst_refuse <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (hst_req && d_cause != `HAPD_C_OK) begin
                        // refused: no target cycle, cause kept for software
                        hst_refuse <= 1'b1;
                        cause_ff <= d_cause;
                        if (refuse_cnt_ff != 8'hff)
                            refuse_cnt_ff <= refuse_cnt_ff + 8'h01;
                    end else if (hst_req && d_local) begin
                        if (d_idx_wr)
                            index_ff <= hst_wdata[13:0];
                        hst_rvalid <= !hst_wr;
                        hst_rdata <= d_ldata;
                    end else if (hst_req) begin
                        tgt_valid <= 1'b1;
                        tgt_group <= d_grp;
                        tgt_addr <= d_off;
                        tgt_wr <= hst_wr;
                        tgt_swap <= d_swap;
                        // agp image costs a slave plus a master cycle
                        tgt_agp_master <= d_grp == `HAPD_G_AGP;
                        if (d_swap) begin
                            tgt_be <= {hst_be[0], hst_be[1], hst_be[2], hst_be[3]};
                            tgt_wdata <= {hst_wdata[7:0], hst_wdata[15:8],
                                hst_wdata[23:16], hst_wdata[31:24]};
                        end else begin
                            tgt_be <= d_split ? lo_be : hst_be;
                            tgt_wdata <= hst_wdata;
                        end
                        if (d_split) begin
                            // lowest lane first, rest follow one a cycle
                            rem_be_ff <= hst_be & ~lo_be;
                            state_ff <= ST_SPLIT;
                            hst_busy <= 1'b1;
                        end
                    end
                end
                ST_SPLIT: begin
                    // the split keeps the data, only the lane moves
                    tgt_valid <= 1'b1;
                    tgt_be <= rem_lo;
                    rem_be_ff <= rem_rest;
                    if (rem_rest == 4'h0) begin
                        state_ff <= ST_IDLE;
                        hst_busy <= 1'b0;
                    end
                    if (hst_req) begin
                        // host ignored busy; cycle dropped
                        hst_refuse <= 1'b1;
                        cause_ff <= `HAPD_C_BUSY;
                        if (refuse_cnt_ff != 8'hff)
                            refuse_cnt_ff <= refuse_cnt_ff + 8'h01;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    hst_busy <= 1'b0;
                end
            endcase
        end
    end

    // software writes to the settings
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= `HAPD_RST_CTRL;
            reg0_base_ff <= 18'h00000;
            reg1_base_ff <= 18'h00000;
            lin0_base_ff <= 6'h00;
            lin1_base_ff <= 6'h00;
            fb_size_ff <= `HAPD_RST_FB_SIZE;
            agp_off_ff <= 26'h0000000;
            agp_code_ff <= 2'h0;
            io_base_ff <= 24'h000000;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `HAPD_SW_CTRL: ctrl_ff <= reg_wdata[5:0];
                `HAPD_SW_REG0_BASE: reg0_base_ff <= reg_wdata[31:14];
                `HAPD_SW_REG1_BASE: reg1_base_ff <= reg_wdata[31:14];
                `HAPD_SW_LIN0_BASE: lin0_base_ff <= reg_wdata[31:26];
                `HAPD_SW_LIN1_BASE: lin1_base_ff <= reg_wdata[31:26];
                `HAPD_SW_FB_SIZE: fb_size_ff <= reg_wdata[25:0];
                `HAPD_SW_AGP_OFF: agp_off_ff <= {reg_wdata[25:2], 2'b00};
                `HAPD_SW_AGP_CODE: agp_code_ff <= reg_wdata[1:0];
                `HAPD_SW_IO_BASE: io_base_ff <= reg_wdata[31:8];
                default: ctrl_ff <= ctrl_ff; // unmapped write ignored
            endcase
        end
    end

    // software read data, one cycle after the strobe
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            if (reg_rd) begin
                case (reg_addr)
                    `HAPD_SW_CTRL: reg_rdata <= {26'h0000000, ctrl_ff};
                    `HAPD_SW_REG0_BASE: reg_rdata <= {reg0_base_ff, 14'h0000};
                    `HAPD_SW_REG1_BASE: reg_rdata <= {reg1_base_ff, 14'h0000};
                    `HAPD_SW_LIN0_BASE: reg_rdata <= {lin0_base_ff, 26'h0000000};
                    `HAPD_SW_LIN1_BASE: reg_rdata <= {lin1_base_ff, 26'h0000000};
                    `HAPD_SW_FB_SIZE: reg_rdata <= {6'h00, fb_size_ff};
                    `HAPD_SW_AGP_OFF: reg_rdata <= {6'h00, agp_off_ff};
                    `HAPD_SW_AGP_CODE: reg_rdata <= {30'h00000000, agp_code_ff};
                    `HAPD_SW_IO_BASE: reg_rdata <= {io_base_ff, 8'h00};
                    `HAPD_SW_STATUS: reg_rdata <= {16'h0000, refuse_cnt_ff,
                        4'h0, cause_ff, state_ff};
                    default: reg_rdata <= 32'h00000000; // unmapped reads zero
                endcase
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end
    end
endmodule

// *** dv/hapd_host_model.sv ***
// Purpose: host bus controller model issuing decoder host cycles
// Assumes: request held for one clock
// Notes: released address and data show their inverse
`timescale 1ns/1ps
module hapd_host_model (
    input wire mclk,
    output logic hst_req,
    output logic [1:0] hst_space,
    output logic hst_wr,
    output logic [31:0] hst_addr,
    output logic [3:0] hst_be,
    output logic [31:0] hst_wdata
);
    // idle bus from time zero
    initial begin
        hst_req = 1'b0;
        hst_space = 2'h0;
        hst_wr = 1'b0;
        hst_addr = 32'h0;
        hst_be = 4'h0;
        hst_wdata = 32'h0;
    end
    // one cycle, then release; returns once the answer has landed
    task automatic cyc(input logic [1:0] sp, input logic w, input logic [31:0] a,
            input logic [3:0] b, input logic [31:0] d);
        @(posedge mclk);
        hst_req <= 1'b1;
        hst_space <= sp;
        hst_wr <= w;
        hst_addr <= a;
        hst_be <= b;
        hst_wdata <= d;
        @(posedge mclk);
        hst_req <= 1'b0;
        hst_addr <= ~a;
        hst_wdata <= ~d;
        #1;
    endtask
endmodule

// *** dv/hapd_monitor.sv ***
// Purpose: assertion checker for the host aperture decoder
// Assumes: one mclk domain, clk_en high
// Notes: tracks aperture 0 base from software writes
`timescale 1ns/1ps
`include "hapd_map.vh"
module hapd_monitor (
    input wire mclk,
    input wire nrst,
    input wire clk_en,
    input wire hst_req,
    input wire [1:0] hst_space,
    input wire hst_wr,
    input wire [31:0] hst_addr,
    input wire [3:0] hst_be,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire tgt_valid,
    input wire [3:0] tgt_group,
    input wire [3:0] tgt_be,
    input wire tgt_swap,
    input wire tgt_agp_master,
    input wire hst_rvalid,
    input wire hst_refuse,
    input wire hst_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // aperture 0 base as software last set it
    logic [17:0] ap0_ff;
    wire [17:0] nxt_ap0 = (clk_en && reg_wr && reg_addr == `HAPD_SW_REG0_BASE) ?
        reg_wdata[31:14] : ap0_ff;
    // a fresh memory request landing in aperture 0
    wire hit0 = hst_req && clk_en && !hst_busy && hst_space == `HAPD_SP_MEM &&
        hst_addr[31:14] == ap0_ff;
    wire [13:0] off = hst_addr[13:0];
    // base tracker, cleared with the design
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ap0_ff <= 18'h0;
        end else begin
            ap0_ff <= nxt_ap0;
        end
    end
    a_refuse_has_cause: assert property (hst_refuse && $past(clk_en) |-> $past(hst_req))
        else $error("refusal without a request");
    a_gui_dword_only: assert property (hit0 && off >= 14'h1400 && off < 14'h2000 &&
        hst_be != 4'hf |=> hst_refuse && !tgt_valid)
        else $error("narrow drawing access not refused");
    a_mirror_read_only: assert property (hit0 && hst_wr && off[13:8] == 6'h0f
        |=> hst_refuse && !tgt_valid)
        else $error("mirror write not refused");
    a_local_answer: assert property (hst_rvalid && $past(clk_en)
        |-> $past(hst_req) && !$past(hst_wr))
        else $error("read answer without read request");
    a_fwd_has_cause: assert property (tgt_valid && $past(clk_en) && !$past(hst_busy)
        |-> $past(hst_req))
        else $error("target cycle without request");
    a_split_byte: assert property (hst_busy |-> tgt_valid && $onehot(tgt_be) &&
        tgt_group == `HAPD_G_VGAIO)
        else $error("split cycle not a single byte");
    a_split_rising: assert property ($past(hst_busy) && tgt_valid && $past(clk_en)
        |-> $onehot(tgt_be) && tgt_be > $past(tgt_be))
        else $error("split lanes not ascending");
    a_agp_pairs: assert property (tgt_agp_master |-> tgt_valid &&
        tgt_group == `HAPD_G_AGP)
        else $error("bus master cycle outside agp image");
    a_swap_linear: assert property (tgt_swap && tgt_valid |->
        tgt_group == `HAPD_G_FB || tgt_group == `HAPD_G_AGP)
        else $error("byte swap outside linear window");
endmodule
bind hapd_top hapd_monitor u_mon (
    .mclk, .nrst, .clk_en, .hst_req, .hst_space, .hst_wr, .hst_addr, .hst_be,
    .reg_addr, .reg_wdata, .reg_wr, .tgt_valid, .tgt_group, .tgt_be, .tgt_swap,
    .tgt_agp_master, .hst_rvalid, .hst_refuse, .hst_busy
);

// *** dv/test_host_aperture_decoder.sv ***
// Purpose: self-checking bench for the host aperture decoder
// Assumes: clk_en held high, cycles from the host model
// Notes: bases set apart before host decode
`timescale 1ns/1ps
`include "hapd_map.vh"
module test_host_aperture_decoder;
    typedef struct packed {
        logic [1:0] sp;
        logic wr;
        logic [31:0] a;
        logic [3:0] be;
        logic rf;
        logic [3:0] grp;
        logic sw;
        logic agp;
    } hapd_row_t;
    localparam logic [31:0] AP0 = 32'h1000_0000;
    localparam logic [31:0] AP1 = 32'h1000_4000;
    localparam logic [31:0] LN0 = 32'h4000_0000;
    localparam logic [31:0] LN1 = 32'h8000_0000;
    localparam logic [31:0] IOB = 32'h0000_1000;
    logic mclk, nrst, clk_en, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    wire [31:0] reg_rdata, tgt_wdata, hst_rdata, hst_addr, hst_wdata;
    wire [3:0] tgt_group, tgt_be, hst_be;
    wire [1:0] hst_space;
    wire tgt_valid, tgt_swap, tgt_agp_master, hst_rvalid, hst_refuse, hst_busy;
    wire hst_req, hst_wr, tgt_wr;
    wire [25:0] tgt_addr;
    int failures = 0;
    int cmp_count = 0;
    hapd_row_t rows [0:15];
    hapd_host_model host (.mclk(mclk), .hst_req(hst_req), .hst_space(hst_space),
        .hst_wr(hst_wr), .hst_addr(hst_addr), .hst_be(hst_be), .hst_wdata(hst_wdata));
    hapd_top dut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .hst_req(hst_req),
        .hst_space(hst_space), .hst_wr(hst_wr), .hst_addr(hst_addr), .hst_be(hst_be),
        .hst_wdata(hst_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tgt_valid(tgt_valid),
        .tgt_group(tgt_group), .tgt_addr(tgt_addr), .tgt_be(tgt_be), .tgt_wr(tgt_wr),
        .tgt_wdata(tgt_wdata), .tgt_swap(tgt_swap), .tgt_agp_master(tgt_agp_master),
        .hst_rvalid(hst_rvalid), .hst_rdata(hst_rdata), .hst_refuse(hst_refuse),
        .hst_busy(hst_busy));
    // 25 MHz clock
    always #20 mclk = ~mclk;
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // software write, one strobe cycle
    task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // software read, data taken the cycle after
    task automatic sw_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask
    // split io cycle: n byte cycles, lowest lane first
    task automatic split(input logic [31:0] a, input logic [3:0] b, input int n);
        host.cyc(`HAPD_SP_IO, 1'b1, a, b, 32'h0);
        for (int i = 0; i < n; i++) begin
            chk("split_be", tgt_be, 32'h1 << i);
            chk("split_valid", tgt_valid, 32'h1);
            chk("split_busy", hst_busy, (i < n - 1) ? 32'h1 : 32'h0);
            @(posedge mclk) #1;
        end
    endtask
    // verdict, reached from the main sequence or the watchdog
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        test_done;
    end
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        rows[0] = '{0, 0, AP0 + 32'h10, 4'hf, 0, 4'h2, 0, 0};
        rows[1] = '{1, 0, IOB + 32'h10, 4'h4, 0, 4'h1, 0, 0};
        rows[2] = '{0, 1, AP0 + 32'h200, 4'hf, 0, 4'h2, 0, 0};
        rows[3] = '{1, 0, IOB + 32'h200, 4'hf, 1, 4'h0, 0, 0};
        rows[4] = '{0, 0, AP0 + 32'hf00, 4'hf, 0, 4'h3, 0, 0};
        rows[5] = '{0, 1, AP0 + 32'hf04, 4'hf, 1, 4'h0, 0, 0};
        rows[6] = '{0, 1, AP0 + 32'h1000, 4'hf, 0, 4'h4, 0, 0};
        rows[7] = '{0, 1, AP1 + 32'h1400, 4'hf, 0, 4'h5, 0, 0};
        rows[8] = '{0, 1, AP0 + 32'h1404, 4'h1, 1, 4'h0, 0, 0};
        rows[9] = '{2, 0, 32'h10, 4'hf, 0, 4'h6, 0, 0};
        rows[10] = '{0, 0, 32'ha0000, 4'hf, 0, 4'h8, 0, 0};
        rows[11] = '{0, 0, LN0 + 32'hfffffc, 4'hf, 0, 4'h9, 0, 0};
        rows[12] = '{0, 0, LN1 + 32'h10, 4'hf, 0, 4'h9, 1, 0};
        rows[13] = '{0, 1, LN0 + 32'h23ffffc, 4'hf, 0, 4'ha, 0, 1};
        rows[14] = '{0, 1, AP0 + 32'hc, 4'h1, 0, 4'hb, 0, 0};
        rows[15] = '{0, 1, AP0 + 32'hc, 4'h3, 1, 4'h0, 0, 0};
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        // reset values, unmapped and read-only places
        sw_rd(`HAPD_SW_CTRL, 32'h0);
        sw_rd(`HAPD_SW_FB_SIZE, 32'h200_0000);
        sw_rd(8'h28, 32'h0);
        @(posedge mclk) #1 chk("rdata_idle", reg_rdata, 32'h0);
        sw_wr(`HAPD_SW_STATUS, 32'hffff_ffff);
        sw_rd(`HAPD_SW_STATUS, 32'h0);
        $display("test reset done");
        // set every window apart
        sw_wr(`HAPD_SW_REG0_BASE, AP0);
        sw_wr(`HAPD_SW_REG1_BASE, AP1);
        sw_wr(`HAPD_SW_LIN0_BASE, LN0);
        sw_wr(`HAPD_SW_LIN1_BASE, LN1);
        sw_wr(`HAPD_SW_IO_BASE, IOB);
        sw_wr(`HAPD_SW_FB_SIZE, 32'h100_0000);
        sw_wr(`HAPD_SW_AGP_OFF, 32'h200_0000);
        sw_wr(`HAPD_SW_CTRL, 32'h31);
        foreach (rows[i]) begin
            host.cyc(rows[i].sp, rows[i].wr, rows[i].a, rows[i].be, 32'h0);
            chk("refuse", hst_refuse, rows[i].rf);
            chk("valid", tgt_valid, !rows[i].rf);
            if (!rows[i].rf) begin
                chk("group", tgt_group, rows[i].grp);
                chk("be", tgt_be, rows[i].be);
                chk("swap", tgt_swap, rows[i].sw);
                chk("agp", tgt_agp_master, rows[i].agp);
                chk("wr", tgt_wr, rows[i].wr);
            end
        end
        $display("test rows done");
        // frame end reached past the installed size
        host.cyc(`HAPD_SP_MEM, 1'b0, LN0 + 32'h100_0000, 4'hf, 32'h0);
        chk("fb_end", tgt_group === `HAPD_G_FB && tgt_valid, 32'h0);
        // indirect index then data returns aperture 0 base
        host.cyc(`HAPD_SP_IO, 1'b1, IOB, 4'hf, 32'hf18);
        host.cyc(`HAPD_SP_IO, 1'b0, IOB + 32'h4, 4'hf, 32'h0);
        chk("idx_rvalid", hst_rvalid, 32'h1);
        chk("idx_rdata", hst_rdata, AP0);
        host.cyc(`HAPD_SP_MEM, 1'b0, AP0 + 32'hf8, 4'hf, 32'h0);
        chk("ap1_base", hst_rdata, AP1);
        host.cyc(`HAPD_SP_MEM, 1'b0, AP1 + 32'hf0, 4'hf, 32'h0);
        chk("lin0_base", hst_rdata, LN0);
        host.cyc(`HAPD_SP_MEM, 1'b0, AP0 + 32'hf4, 4'hf, 32'h0);
        chk("lin1_base", hst_rdata, LN1);
        $display("test index done");
        // big-endian window reverses data bytes
        host.cyc(`HAPD_SP_MEM, 1'b1, LN1 + 32'h20, 4'hf, 32'h1122_3344);
        chk("be_data", tgt_wdata, 32'h4433_2211);
        chk("addr", tgt_addr, 32'h20);
        // vga port and palette splits back to back
        split(32'h3c4, 4'hf, 4);
        split(32'h3c8, 4'h3, 2);
        $display("test split done");
        // width refusal leaves its cause in status
        host.cyc(`HAPD_SP_MEM, 1'b1, AP0 + 32'h1400, 4'h3, 32'h0);
        chk("width_ref", hst_refuse, 32'h1);
        sw_rd(`HAPD_SW_STATUS, 32'h0000_0604);
        $display("test status done");
        test_done;
    end
endmodule
